// ===== logic/video_encoder_pkg.sv
`default_nettype none
package video_encoder_pkg;

    // subaddresses of the configuration bytes
    localparam logic [7:0] SUB_STD_CTRL  = 8'h61;
    localparam logic [7:0] SUB_BURST     = 8'h62;
    localparam logic [7:0] SUB_FSC_BYTE0 = 8'h63;
    localparam logic [7:0] SUB_FSC_BYTE1 = 8'h64;
    localparam logic [7:0] SUB_FSC_BYTE2 = 8'h65;
    localparam logic [7:0] SUB_FSC_BYTE3 = 8'h66;
    localparam logic [7:0] SUB_CAPTION   = 8'h67;

    // field positions in the standard control byte
    localparam int BIT_RGB_DOWN    = 7;
    localparam int BIT_CVBS_DOWN   = 6;
    localparam int BIT_PHASE_INV   = 5;
    localparam int BIT_LUMA_GAIN   = 4;
    localparam int BIT_SECAM       = 3;
    localparam int BIT_CHROMA_BW   = 2;
    localparam int BIT_PAL         = 1;
    localparam int BIT_LINE_LENGTH = 0;
    // field positions in the burst byte
    localparam int BIT_RTC_ENABLE  = 7;

    // reset values
    localparam logic [7:0]  STD_CTRL_RESET = 8'h86;
    localparam logic [7:0]  BURST_RESET    = 8'h2F;
    localparam logic [31:0] FSC_RESET      = 32'h0000_0000;
    localparam logic [7:0]  CAPTION_RESET  = 8'h00;

    // line lengths in pixel clocks
    localparam logic [9:0] LINE_LEN_864 = 10'h360;
    localparam logic [9:0] LINE_LEN_858 = 10'h35A;

    // burst amplitude used while SECAM is active
    localparam logic [6:0] SECAM_BURST_AMP = 7'h2F;

    localparam logic [3:0] CAPTION_BITS = 4'h8;

    typedef struct packed {
        logic       rgb_dac_powerdown;
        logic       composite_dac_powerdown;
        logic       alt_phase_invert;
        logic       luma_gain_select;
        logic       secam_enable;
        logic       chroma_bandwidth_select;
        logic       pal_select;
        logic       line_length_select;
    } std_ctrl_t;

    typedef struct packed {
        logic       realtime_subcarrier_enable;
        logic [6:0] burst_amplitude;
    } burst_ctrl_t;

    typedef struct packed {
        logic       wr_en;
        logic [7:0] sub_addr;
        logic [7:0] wr_data;
    } sub_write_t;

    typedef enum logic [1:0] {
        CAP_IDLE  = 2'b01,
        CAP_SHIFT = 2'b10
    } caption_state_t;

endpackage : video_encoder_pkg
`default_nettype wire

// ===== logic/video_encoder_standard_config.sv
`timescale 1ns/10ps
`default_nettype none
module video_encoder_standard_config #(
    parameter int PHASE_BITS         = 12,
    parameter int CAPTION_BIT_CYCLES = 64
) (
    input  wire logic                            core_clk,                 // 40 MHz
    input  wire logic                            reset,                    // sync, high
    input  wire video_encoder_pkg::sub_write_t   host_write,               // subaddress write
    input  wire logic [7:0]                      rd_sub_addr,              // read subaddress
    output logic [7:0]                           rd_data,                  // read byte
    input  wire logic                            rtc_valid,                // decoder word strobe
    input  wire logic [31:0]                     rtc_increment,            // decoder increment
    input  wire logic                            caption_start,            // framing code done
    output logic                                 rgb_dac_force_low,        // R,G,B at lowest
    output logic                                 composite_dac_force_low,  // CVBS,Y,C at lowest
    output logic                                 pal_phase_inverted,       // switch inverted
    output logic                                 luma_setup_92p5,          // 92.5 IRE gain
    output logic                                 secam_active,             // SECAM encoding
    output logic                                 chroma_standard_bw,       // standard bandwidth
    output logic                                 pal_mode,                 // alternating V
    output logic [9:0]                           line_total,               // clocks per line
    output logic                                 line_start,               // first clock of line
    output logic [6:0]                           burst_amp_out,            // effective burst
    output logic [PHASE_BITS-1:0]                subcarrier_phase,         // accumulator top
    output logic                                 caption_bit,              // serial caption
    output logic                                 caption_busy              // caption shifting
);

    localparam logic [15:0] CAP_DIV_LAST = 16'(CAPTION_BIT_CYCLES - 1);

    typedef struct packed {
        video_encoder_pkg::std_ctrl_t      std_ctrl;
        video_encoder_pkg::burst_ctrl_t    burst;
        logic [31:0]                       subcarrier_increment;
        logic [7:0]                        caption;
        logic [7:0]                        rd_data;
        logic                              rtc_valid_s1;
        logic                              rtc_valid_s2;
        logic                              rtc_valid_s3;
        logic [31:0]                       rtc_word_s1;
        logic [31:0]                       rtc_word_s2;
        logic [31:0]                       rtc_word;
        logic                              rtc_seen;
        logic [31:0]                       phase_acc;
        logic [9:0]                        pixel_count;
        logic [9:0]                        line_total;
        logic                              line_start;
        logic                              phase_inv;
        logic [6:0]                        burst_amp;
        video_encoder_pkg::caption_state_t cap_state;
        logic [7:0]                        cap_shift;
        logic [3:0]                        cap_count;
        logic [15:0]                       cap_div;
        logic                              cap_bit;
    } state_t;

    state_t st_reg;
    state_t st_next;

    function automatic logic [7:0] read_byte(input state_t s, input logic [7:0] a);
        case (a)
            video_encoder_pkg::SUB_STD_CTRL:  read_byte = s.std_ctrl;
            video_encoder_pkg::SUB_BURST:     read_byte = s.burst;
            video_encoder_pkg::SUB_FSC_BYTE0: read_byte = s.subcarrier_increment[7:0];
            video_encoder_pkg::SUB_FSC_BYTE1: read_byte = s.subcarrier_increment[15:8];
            video_encoder_pkg::SUB_FSC_BYTE2: read_byte = s.subcarrier_increment[23:16];
            video_encoder_pkg::SUB_FSC_BYTE3: read_byte = s.subcarrier_increment[31:24];
            video_encoder_pkg::SUB_CAPTION:   read_byte = s.caption;
            default:                          read_byte = 8'h00;
        endcase
    endfunction : read_byte

    logic [31:0] increment_now;
    logic        cap_tick;

    always_comb
    begin
        st_next = st_reg;
        cap_tick = (st_reg.cap_div == CAP_DIV_LAST);

        // register writes
        if (host_write.wr_en)
        begin
            case (host_write.sub_addr)
                video_encoder_pkg::SUB_STD_CTRL:  st_next.std_ctrl = host_write.wr_data;
                video_encoder_pkg::SUB_BURST:     st_next.burst = host_write.wr_data;
                video_encoder_pkg::SUB_FSC_BYTE0: st_next.subcarrier_increment[7:0] = host_write.wr_data;
                video_encoder_pkg::SUB_FSC_BYTE1: st_next.subcarrier_increment[15:8] = host_write.wr_data;
                video_encoder_pkg::SUB_FSC_BYTE2: st_next.subcarrier_increment[23:16] = host_write.wr_data;
                video_encoder_pkg::SUB_FSC_BYTE3: st_next.subcarrier_increment[31:24] = host_write.wr_data;
                // parity sits in bit 7 and is passed on untouched
                video_encoder_pkg::SUB_CAPTION:   st_next.caption = host_write.wr_data;
                default:                          st_next.caption = st_reg.caption;
            endcase
        end
        st_next.rd_data = read_byte(st_reg, rd_sub_addr);

        // decoder word arrives from pins: two stages before use
        st_next.rtc_valid_s1 = rtc_valid;
        st_next.rtc_valid_s2 = st_reg.rtc_valid_s1;
        st_next.rtc_valid_s3 = st_reg.rtc_valid_s2;
        st_next.rtc_word_s1 = rtc_increment;
        st_next.rtc_word_s2 = st_reg.rtc_word_s1;
        // word is taken on the strobe's rising edge, by then it has settled
        if (st_reg.rtc_valid_s2 && !st_reg.rtc_valid_s3)
        begin
            st_next.rtc_word = st_reg.rtc_word_s2;
            st_next.rtc_seen = 1'b1;
        end
        if (!st_reg.burst.realtime_subcarrier_enable)
        begin
            st_next.rtc_seen = 1'b0;
        end

        // real-time control overrides the programmed increment
        if (st_reg.burst.realtime_subcarrier_enable && st_reg.rtc_seen)
        begin
            increment_now = st_reg.rtc_word;
        end
        else
        begin
            increment_now = st_reg.subcarrier_increment;
        end
        st_next.phase_acc = st_reg.phase_acc + increment_now;

        // line timing
        st_next.line_total = st_reg.std_ctrl.line_length_select ?
                             video_encoder_pkg::LINE_LEN_858 :
                             video_encoder_pkg::LINE_LEN_864;
        // a shorter line taking effect mid-line wraps at once, never overruns
        if (st_reg.pixel_count >= st_reg.line_total - 10'h001)
        begin
            st_next.pixel_count = 10'h000;
            st_next.line_start = 1'b1;
        end
        else
        begin
            st_next.pixel_count = st_reg.pixel_count + 10'h001;
            st_next.line_start = 1'b0;
        end

        st_next.phase_inv = st_reg.std_ctrl.alt_phase_invert &&
                            st_reg.burst.realtime_subcarrier_enable;
        st_next.burst_amp = st_reg.std_ctrl.secam_enable ?
                            video_encoder_pkg::SECAM_BURST_AMP :
                            st_reg.burst.burst_amplitude;

        // caption serializer, one bit per divider period
        st_next.cap_div = cap_tick ? 16'h0000 : st_reg.cap_div + 16'h0001;
        case (st_reg.cap_state)
            video_encoder_pkg::CAP_IDLE:
            begin
                st_next.cap_bit = 1'b0;
                if (caption_start)
                begin
                    st_next.cap_state = video_encoder_pkg::CAP_SHIFT;
                    st_next.cap_shift = st_reg.caption;
                    st_next.cap_bit = st_reg.caption[0];
                    st_next.cap_count = 4'h0;
                    st_next.cap_div = 16'h0000;
                end
            end
            video_encoder_pkg::CAP_SHIFT:
            begin
                if (cap_tick)
                begin
                    if (st_reg.cap_count == video_encoder_pkg::CAPTION_BITS - 4'h1)
                    begin
                        st_next.cap_state = video_encoder_pkg::CAP_IDLE;
                        st_next.cap_bit = 1'b0;
                    end
                    else
                    begin
                        st_next.cap_shift = {1'b0, st_reg.cap_shift[7:1]};
                        st_next.cap_bit = st_reg.cap_shift[1];
                        st_next.cap_count = st_reg.cap_count + 4'h1;
                    end
                end
            end
            default:
            begin
                st_next.cap_state = video_encoder_pkg::CAP_IDLE;
                st_next.cap_bit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_reg <= '0;
            st_reg.std_ctrl <= video_encoder_pkg::STD_CTRL_RESET;
            st_reg.burst <= video_encoder_pkg::BURST_RESET;
            st_reg.subcarrier_increment <= video_encoder_pkg::FSC_RESET;
            st_reg.caption <= video_encoder_pkg::CAPTION_RESET;
            st_reg.line_total <= video_encoder_pkg::LINE_LEN_864;
            st_reg.burst_amp <= video_encoder_pkg::BURST_RESET[6:0];
            st_reg.cap_state <= video_encoder_pkg::CAP_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rd_data                 = st_reg.rd_data;
    assign rgb_dac_force_low       = st_reg.std_ctrl.rgb_dac_powerdown;
    assign composite_dac_force_low = st_reg.std_ctrl.composite_dac_powerdown;
    assign pal_phase_inverted      = st_reg.phase_inv;
    assign luma_setup_92p5         = st_reg.std_ctrl.luma_gain_select;
    assign secam_active            = st_reg.std_ctrl.secam_enable;
    assign chroma_standard_bw      = st_reg.std_ctrl.chroma_bandwidth_select;
    assign pal_mode                = st_reg.std_ctrl.pal_select;
    assign line_total              = st_reg.line_total;
    assign line_start              = st_reg.line_start;
    assign burst_amp_out           = st_reg.burst_amp;
    assign subcarrier_phase        = st_reg.phase_acc[31 -: PHASE_BITS];
    assign caption_bit             = st_reg.cap_bit;
    assign caption_busy            = st_reg.cap_state == video_encoder_pkg::CAP_SHIFT;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence std_write_s;
        host_write.wr_en && host_write.sub_addr == video_encoder_pkg::SUB_STD_CTRL;
    endsequence

    sequence caption_go_s;
        caption_start && st_reg.cap_state == video_encoder_pkg::CAP_IDLE;
    endsequence

    sequence burst_write_s;
        host_write.wr_en && host_write.sub_addr == video_encoder_pkg::SUB_BURST;
    endsequence

    sequence caption_write_s;
        host_write.wr_en && host_write.sub_addr == video_encoder_pkg::SUB_CAPTION;
    endsequence

    // a bit period ends on the divider tick; a tick of the free-running divider at go is masked, caption_busy is still low then
    sequence bit_end_s;
        caption_busy && cap_tick;
    endsequence

    AST_RGB_FORCE: assert property (std_write_s |=>
        rgb_dac_force_low == $past(host_write.wr_data[video_encoder_pkg::BIT_RGB_DOWN]))
        else $error("rgb dac force does not follow written bit");
    AST_CVBS_FORCE: assert property (std_write_s |=>
        composite_dac_force_low == $past(host_write.wr_data[video_encoder_pkg::BIT_CVBS_DOWN]))
        else $error("composite dac force does not follow written bit");
    AST_PHASE_INV: assert property (##1 pal_phase_inverted ==
        $past(st_reg.std_ctrl.alt_phase_invert && st_reg.burst.realtime_subcarrier_enable))
        else $error("phase inversion without real-time control");
    AST_LINE_TOTAL: assert property (##1 line_total ==
        ($past(st_reg.std_ctrl.line_length_select) ? 10'h35A : 10'h360))
        else $error("line total does not match select bit");
    AST_SECAM_BURST: assert property (secam_active ##1 secam_active |->
        burst_amp_out == video_encoder_pkg::SECAM_BURST_AMP)
        else $error("burst amplitude not fixed under SECAM");
    AST_BURST_AMP: assert property (!secam_active ##1 !secam_active |->
        burst_amp_out == $past(st_reg.burst.burst_amplitude))
        else $error("burst amplitude not taken from register");
    AST_FSC_MSB: assert property (host_write.wr_en &&
        host_write.sub_addr == video_encoder_pkg::SUB_FSC_BYTE3 |=>
        st_reg.subcarrier_increment[31:24] == $past(host_write.wr_data))
        else $error("top increment byte not stored");
    AST_ACCUM: assert property (!st_reg.burst.realtime_subcarrier_enable |=>
        st_reg.phase_acc == $past(st_reg.phase_acc) + $past(st_reg.subcarrier_increment))
        else $error("accumulator did not add increment");
    AST_RTC_USE: assert property (st_reg.burst.realtime_subcarrier_enable &&
        st_reg.rtc_seen |=> st_reg.phase_acc == $past(st_reg.phase_acc) + $past(st_reg.rtc_word))
        else $error("real-time increment not applied");
    AST_CAPTION_LSB: assert property (caption_go_s |=>
        caption_busy && caption_bit == $past(st_reg.caption[0]))
        else $error("caption does not start with bit 0");
    AST_CAPTION_BIT1: assert property (bit_end_s ##0 st_reg.cap_count == 4'h0 |=>
        caption_busy && caption_bit == $past(st_reg.cap_shift[1]))
        else $error("caption second bit wrong");
    AST_CAPTION_DONE: assert property (bit_end_s ##0
        st_reg.cap_count == video_encoder_pkg::CAPTION_BITS - 4'h1 |=> !caption_busy && !caption_bit)
        else $error("caption did not end after eight bits");
    AST_CAPTION_HOLD: assert property (caption_busy && !cap_tick |=>
        caption_busy && $stable(caption_bit))
        else $error("caption bit changed inside its period");
    AST_CAPTION_IDLE: assert property (!caption_busy && !caption_start |=>
        !caption_busy && !caption_bit)
        else $error("caption line not quiet while idle");
    AST_CAPTION_KEEP: assert property (caption_write_s |=>
        st_reg.caption == $past(host_write.wr_data))
        else $error("caption byte not stored as written");

    AST_LUMA_GAIN: assert property (std_write_s |=>
        luma_setup_92p5 == $past(host_write.wr_data[video_encoder_pkg::BIT_LUMA_GAIN]))
        else $error("luma gain select does not follow written bit");
    AST_SECAM_SET: assert property (std_write_s |=>
        secam_active == $past(host_write.wr_data[video_encoder_pkg::BIT_SECAM]))
        else $error("secam enable does not follow written bit");
    AST_CHROMA_BW: assert property (std_write_s |=>
        chroma_standard_bw == $past(host_write.wr_data[video_encoder_pkg::BIT_CHROMA_BW]))
        else $error("chroma bandwidth does not follow written bit");
    AST_PAL_MODE: assert property (std_write_s |=>
        pal_mode == $past(host_write.wr_data[video_encoder_pkg::BIT_PAL]))
        else $error("pal select does not follow written bit");
    AST_RTC_ENABLE: assert property (burst_write_s |=>
        st_reg.burst.realtime_subcarrier_enable ==
        $past(host_write.wr_data[video_encoder_pkg::BIT_RTC_ENABLE]))
        else $error("real-time enable not stored");
    AST_BURST_WRITE: assert property (burst_write_s |=>
        st_reg.burst.burst_amplitude == $past(host_write.wr_data[6:0]))
        else $error("burst amplitude not stored");
    AST_RTC_TAKE: assert property (st_reg.rtc_valid_s2 && !st_reg.rtc_valid_s3 |=>
        st_reg.rtc_word == $past(st_reg.rtc_word_s2))
        else $error("decoder word not taken on strobe edge");
    AST_RTC_OFF: assert property (!st_reg.burst.realtime_subcarrier_enable |=>
        !st_reg.rtc_seen)
        else $error("decoder word kept while real-time control off");
    AST_FSC_LSB: assert property (host_write.wr_en &&
        host_write.sub_addr == video_encoder_pkg::SUB_FSC_BYTE0 |=>
        st_reg.subcarrier_increment[7:0] == $past(host_write.wr_data))
        else $error("low increment byte not stored");
    AST_LINE_WRAP: assert property (st_reg.pixel_count >= st_reg.line_total - 10'h001 |=>
        line_start && st_reg.pixel_count == 10'h000)
        else $error("pixel counter did not wrap at line end");
    AST_LINE_RUN: assert property (st_reg.pixel_count < st_reg.line_total - 10'h001 |=>
        !line_start)
        else $error("line start pulse inside a line");

endmodule : video_encoder_standard_config
`default_nettype wire

// ===== tb/video_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module video_host_model (
    input  wire logic                          core_clk,       // pixel clock
    output video_encoder_pkg::sub_write_t      host_write,     // subaddress write
    output logic                               rtc_valid,      // decoder strobe
    output logic [31:0]                        rtc_increment   // decoder word
);
    initial
    begin
        host_write    = '0;
        rtc_valid     = 1'b0;
        rtc_increment = 32'h0000_0000;
    end

    // one-cycle strobe, then a released bus shows the inverse so stale data cannot pass
    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        host_write = '{wr_en: 1'b1, sub_addr: addr, wr_data: data};
        @(negedge core_clk);
        host_write = '{wr_en: 1'b0, sub_addr: ~addr, wr_data: ~data};
        @(negedge core_clk);
    endtask : write_byte

    // word settles a cycle ahead and is held past the 3-cycle capture window
    task automatic send_rtc(input logic [31:0] word);
        rtc_increment = word;
        @(negedge core_clk);
        rtc_valid = 1'b1;
        repeat (4) @(negedge core_clk);
        rtc_valid = 1'b0;
        rtc_increment = ~word;
        repeat (4) @(negedge core_clk);
    endtask : send_rtc
endmodule : video_host_model
`default_nettype wire

// ===== tb/tb_video_encoder_standard_config.sv
`timescale 1ns/10ps
`default_nettype none
module tb_video_encoder_standard_config;
    localparam int CAP_CYC = 4;
    logic                          core_clk;
    logic                          reset;
    logic                          caption_start;
    logic [7:0]                    rd_sub_addr;
    video_encoder_pkg::sub_write_t host_write;
    logic                          rtc_valid;
    logic [31:0]                   rtc_increment;
    logic [7:0]                    rd_data;
    logic                          rgb_low, comp_low, ph_inv, luma_92, secam, std_bw, pal;
    logic                          cap_bit, cap_busy, line_start;
    logic [9:0]                    line_total;
    logic [6:0]                    burst;
    logic [11:0]                   phase;
    logic [7:0]                    pat [4] = '{8'h00, 8'hF7, 8'h59, 8'hA2};
    logic [7:0]                    rst_img [8] = '{8'h00, 8'h86, 8'h2F, 8'h00, 8'h00, 8'h00,
                                                  8'h00, 8'h00};
    int                            n_mismatch = 0;
    int                            n_tests = 0;
    int                            cycles = 0;

    video_host_model u_video_host_model (
        .core_clk(core_clk), .host_write(host_write), .rtc_valid(rtc_valid),
        .rtc_increment(rtc_increment)
    );

    video_encoder_standard_config #(.PHASE_BITS(12), .CAPTION_BIT_CYCLES(CAP_CYC))
    u_video_encoder_standard_config (
        .core_clk(core_clk), .reset(reset), .host_write(host_write),
        .rd_sub_addr(rd_sub_addr), .rd_data(rd_data), .rtc_valid(rtc_valid),
        .rtc_increment(rtc_increment), .caption_start(caption_start),
        .rgb_dac_force_low(rgb_low), .composite_dac_force_low(comp_low),
        .pal_phase_inverted(ph_inv), .luma_setup_92p5(luma_92), .secam_active(secam),
        .chroma_standard_bw(std_bw), .pal_mode(pal), .line_total(line_total),
        .line_start(line_start), .burst_amp_out(burst), .subcarrier_phase(phase),
        .caption_bit(cap_bit), .caption_busy(cap_busy)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    always @(posedge core_clk)
    begin
        cycles++;
        // four line period checks dominate, about 7000 cycles in all
        if (cycles == 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic do_reset();
        reset = 1'b1;
        repeat (10) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
    endtask : do_reset

    task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
        rd_sub_addr = addr;
        repeat (2) @(negedge core_clk);
        check("rd_data", {24'h0, exp}, {24'h0, rd_data});
    endtask : read_check

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        u_video_host_model.write_byte(addr, data);
        repeat (2) @(negedge core_clk);
    endtask : wr

    task automatic step_check(input logic [11:0] exp);
        logic [11:0] p0;
        p0 = phase;
        @(negedge core_clk);
        check("subcarrier_phase step", {20'h0, exp}, {20'h0, phase - p0});
    endtask : step_check

    task automatic std_check(input logic [7:0] p, input logic rtc);
        check("rgb_dac_force_low", {31'h0, p[7]}, {31'h0, rgb_low});
        check("composite_dac_force_low", {31'h0, p[6]}, {31'h0, comp_low});
        check("pal_phase_inverted", {31'h0, p[5] & rtc}, {31'h0, ph_inv});
        check("luma_setup_92p5", {31'h0, p[4]}, {31'h0, luma_92});
        check("secam_active", {31'h0, p[3]}, {31'h0, secam});
        check("chroma_standard_bw", {31'h0, p[2]}, {31'h0, std_bw});
        check("pal_mode", {31'h0, p[1]}, {31'h0, pal});
        check("line_total", {22'h0, p[0] ? 10'h35A : 10'h360}, {22'h0, line_total});
    endtask : std_check

    // first pulse found may close a cut line, so measure the one after it
    task automatic line_check(input int exp);
        int n;
        n = 0;
        while (line_start !== 1'b1)
            @(negedge core_clk);
        @(negedge core_clk);
        while (line_start !== 1'b1)
        begin
            n++;
            @(negedge core_clk);
        end
        check("line_start period", 32'(exp), 32'(n + 1));
    endtask : line_check

    initial
    begin
        reset = 1'b1;
        rd_sub_addr = 8'h00;
        caption_start = 1'b0;
        do_reset();
        for (int i = 0; i < 8; i++)
            read_check(8'h60 + 8'(i), rst_img[i]);
        std_check(8'h86, 1'b0);
        check("burst_amp_out", 32'h0000_002F, {25'h0, burst});
        // example NTSC increment, one byte per subaddress, low byte first
        wr(8'h63, 8'h1F);
        wr(8'h64, 8'h7C);
        wr(8'h65, 8'hF0);
        wr(8'h66, 8'h21);
        read_check(8'h63, 8'h1F);
        read_check(8'h66, 8'h21);
        wr(8'h6A, 8'h55);
        read_check(8'h6A, 8'h00);
        // every control bit seen both ways with real-time control on
        wr(8'h62, 8'h80);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h61, pat[i]);
            std_check(pat[i], 1'b1);
            check("burst_amp_out", {25'h0, pat[i][3] ? 7'h2F : 7'h00}, {25'h0, burst});
            read_check(8'h61, pat[i]);
            line_check(pat[i][0] ? 858 : 864);
        end
        wr(8'h61, 8'h20);
        wr(8'h62, 8'h43);
        std_check(8'h20, 1'b0);
        check("burst_amp_out", 32'h0000_0043, {25'h0, burst});
        read_check(8'h62, 8'h43);
        // increments with clean low bits make the top-bit step exact
        do_reset();
        wr(8'h65, 8'h10);
        step_check(12'h001);
        wr(8'h66, 8'h01);
        step_check(12'h011);
        wr(8'h62, 8'h80);
        u_video_host_model.send_rtc(32'h0020_0000);
        step_check(12'h002);
        wr(8'h62, 8'h00);
        step_check(12'h011);
        u_video_host_model.send_rtc(32'h0030_0000);
        step_check(12'h011);
        // odd parity supplied by software in bit 7
        wr(8'h67, 8'hC1);
        read_check(8'h67, 8'hC1);
        caption_start = 1'b1;
        @(negedge core_clk);
        caption_start = 1'b0;
        repeat (2) @(negedge core_clk);
        for (int b = 0; b < 8; b++)
        begin
            check("caption_busy", 32'h1, {31'h0, cap_busy});
            check("caption_bit", {31'h0, b == 0 || b >= 6}, {31'h0, cap_bit});
            repeat (CAP_CYC) @(negedge core_clk);
        end
        check("caption_busy", 32'h0, {31'h0, cap_busy});
        stop_test();
    end
endmodule : tb_video_encoder_standard_config
`default_nettype wire
